// ### hdl/fes_regs.vh
`ifndef FES_REGS_VH
`define FES_REGS_VH

// ****************************************
// Clock and timing figures
// ****************************************
`define FES_CLK_PERIOD_NS 4
`define FES_SMALL_ERASE_US 60000
`define FES_MID_ERASE_US 200000
`define FES_LARGE_ERASE_US 350000
`define FES_WHOLE_ERASE_US 2000000
`define FES_PROGRAM_US 600
`define FES_SUSPEND_LATENCY_US 2
`define FES_PD_ENTRY_US 3
`define FES_RELEASE_US 3
`define FES_RESUME_MAX_NS 200

// ****************************************
// Opcodes
// ****************************************
`define FES_OP_WRITE_ENABLE_CMD 8'h06
`define FES_OP_RDSR1 8'h05
`define FES_OP_RDSR2 8'h35
`define FES_OP_ERASE_4K 8'h20
`define FES_OP_ERASE_32K 8'h52
`define FES_OP_ERASE_64K 8'hd8
`define FES_OP_CHIP_A 8'hc7
`define FES_OP_CHIP_B 8'h60
`define FES_OP_PROG 8'h02
`define FES_OP_QPROG 8'h33
`define FES_OP_SUSPEND 8'h75
`define FES_OP_RESUME 8'h7a
`define FES_OP_PD 8'hb9
`define FES_OP_RELEASE 8'hab

// ****************************************
// Operation kinds and frame lengths
// ****************************************
`define FES_KIND_4K 3'h0
`define FES_KIND_32K 3'h1
`define FES_KIND_64K 3'h2
`define FES_KIND_CHIP 3'h3
`define FES_KIND_PROG 3'h4
`define FES_LEN_OP 3'h1
`define FES_LEN_ADDR 3'h4
`define FES_LEN_DATA 3'h5
`define FES_BIT_LAST 3'h7
`define FES_BIT_FIRST 3'h0

// ****************************************
// Address masks and status layout
// ****************************************
`define FES_MASK_4K 24'hfff000
`define FES_MASK_32K 24'hff8000
`define FES_MASK_64K 24'hff0000
`define FES_SR1_PAD 6'h00
`define FES_SR2_PAD 7'h00

`endif

// ### hdl/fes_core.v
`timescale 1ns/10ps
`default_nettype none
`include "fes_regs.vh"

// Notes on behaviour
// - Opcode 20h plus address erases 4 kB
// - Opcode 52h plus address erases 32 kB
// - Opcode D8h plus address erases 64 kB
// - C7h or 60h erases whole array
// - Erase runs only if select ends aligned
// - Select rise starts self-timed erase
// - Busy high during erase, status readable
// - Busy rising clears the write latch
// - Suspend ignored during whole-array erase
// - Erase suspended blocks erases, status writes
// - Program suspended blocks programs and erases
// - Suspend only when flag 0, busy 1
// - Suspend sets flag, busy drops within latency
// - Resume only when flag 1, busy 0
// - Resume clears flag, busy within 200 ns
// - Power loss clears suspend, abandons operation
// - Power-down only on exact opcode boundary
// - Power-down answers only the release opcode
// - Power-up always lands in standby
// - Release opcode wakes after release delay
// - Write enable command sets write latch
module fes_core #(
  parameter [31:0] SMALL_ERASE_CYC = `FES_SMALL_ERASE_US * (1000 / `FES_CLK_PERIOD_NS),
  parameter [31:0] MID_ERASE_CYC = `FES_MID_ERASE_US * (1000 / `FES_CLK_PERIOD_NS),
  parameter [31:0] LARGE_ERASE_CYC = `FES_LARGE_ERASE_US * (1000 / `FES_CLK_PERIOD_NS),
  parameter [31:0] WHOLE_ERASE_CYC = `FES_WHOLE_ERASE_US * (1000 / `FES_CLK_PERIOD_NS),
  parameter [31:0] PROGRAM_CYC = `FES_PROGRAM_US * (1000 / `FES_CLK_PERIOD_NS)
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Serial link pins
  input wire cs_n_i,
  input wire sck_i,
  input wire mosi_i,
  output wire miso_o,
  output wire miso_oe_o,
  // Array operation request
  output reg op_start_o,
  output reg [2:0] op_kind_o,
  output reg [23:0] op_addr_o,
  output reg op_done_o,
  // Status
  output wire busy_o,
  output wire write_latch_flag_o,
  output wire suspend_flag_o,
  output wire powerdown_o
);

  // ****************************************
  // Timing counts
  // ****************************************
  localparam [31:0] SUS_CYC = `FES_SUSPEND_LATENCY_US * (1000 / `FES_CLK_PERIOD_NS);
  localparam [31:0] PD_CYC = `FES_PD_ENTRY_US * (1000 / `FES_CLK_PERIOD_NS);
  localparam [31:0] REL_CYC = `FES_RELEASE_US * (1000 / `FES_CLK_PERIOD_NS);

  // ****************************************
  // States
  // ****************************************
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_RUN = 7'h02;
  localparam [6:0] ST_SUSPENDING = 7'h04;
  localparam [6:0] ST_SUSP = 7'h08;
  localparam [6:0] ST_PD_ENTER = 7'h10;
  localparam [6:0] ST_PD = 7'h20;
  localparam [6:0] ST_RELEASE = 7'h40;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // The link clock is only sampled; at 64 ns it spans sixteen core cycles.
  reg cs_q1, cs_q2, cs_q3;
  reg sck_q1, sck_q2, sck_q3;
  reg mosi_q1, mosi_q2;

  always @(posedge clk_i) begin
    if (srst_i) begin
      cs_q1 <= 1'b1;
      cs_q2 <= 1'b1;
      cs_q3 <= 1'b1;
      sck_q1 <= 1'b0;
      sck_q2 <= 1'b0;
      sck_q3 <= 1'b0;
      mosi_q1 <= 1'b0;
      mosi_q2 <= 1'b0;
    end else begin
      cs_q1 <= cs_n_i;
      cs_q2 <= cs_q1;
      cs_q3 <= cs_q2;
      sck_q1 <= sck_i;
      sck_q2 <= sck_q1;
      sck_q3 <= sck_q2;
      mosi_q1 <= mosi_i;
      mosi_q2 <= mosi_q1;
    end
  end

  wire active = ~cs_q2;
  wire sck_rise = active & sck_q2 & ~sck_q3;
  wire sck_fall = active & ~sck_q2 & sck_q3;
  wire cs_rise = cs_q2 & ~cs_q3;

  // ****************************************
  // Frame shifter
  // ****************************************
  reg [7:0] shift_q;
  reg [2:0] bitcnt_q;
  reg [2:0] nbytes_q;
  reg [7:0] op_q;
  reg [23:0] addr_q;
  wire [7:0] byte_in = {shift_q[6:0], mosi_q2};
  wire byte_done = sck_rise & (bitcnt_q == `FES_BIT_LAST);

  always @(posedge clk_i) begin
    if (srst_i || !active) begin
      shift_q <= 8'h00;
      bitcnt_q <= `FES_BIT_FIRST;
      nbytes_q <= 3'h0;
      if (srst_i) begin
        op_q <= 8'h00;
        addr_q <= 24'h000000;
      end
    end else if (sck_rise) begin
      shift_q <= byte_in;
      bitcnt_q <= bitcnt_q + 3'h1;
      if (byte_done) begin
        if (nbytes_q == 3'h0)
          op_q <= byte_in;
        else if (nbytes_q < `FES_LEN_ADDR)
          addr_q <= {addr_q[15:0], byte_in};
        if (nbytes_q != `FES_LEN_DATA)
          nbytes_q <= nbytes_q + 3'h1;
      end
    end
  end

  // Frame must end with select rising right on a byte boundary
  wire aligned = cs_rise & (bitcnt_q == `FES_BIT_FIRST);
  wire f_op = aligned & (nbytes_q == `FES_LEN_OP);
  wire f_addr = aligned & (nbytes_q == `FES_LEN_ADDR);
  wire f_data = aligned & (nbytes_q == `FES_LEN_DATA);

  // ****************************************
  // Sequencer
  // ****************************************
  reg [6:0] state_q, state_d;
  reg [31:0] timer_q, timer_d;
  reg [31:0] wait_q, wait_d;
  reg [2:0] kind_q, kind_d;
  reg wel_q, wel_d;
  reg sus_q, sus_d;
  reg start_d;
  reg [23:0] start_addr_d;

  wire is_erase_blk = (op_q == `FES_OP_ERASE_4K) | (op_q == `FES_OP_ERASE_32K) |
                      (op_q == `FES_OP_ERASE_64K);
  wire is_chip = (op_q == `FES_OP_CHIP_A) | (op_q == `FES_OP_CHIP_B);
  wire is_prog = (op_q == `FES_OP_PROG) | (op_q == `FES_OP_QPROG);

  always @* begin
    state_d = state_q;
    timer_d = timer_q;
    wait_d = wait_q;
    kind_d = kind_q;
    wel_d = wel_q;
    sus_d = sus_q;
    start_d = 1'b0;
    start_addr_d = 24'h000000;
    case (state_q)
      ST_IDLE: begin
        if (f_op && op_q == `FES_OP_WRITE_ENABLE_CMD) begin
          wel_d = 1'b1;
        end else if (f_op && op_q == `FES_OP_PD) begin
          state_d = ST_PD_ENTER;
          wait_d = PD_CYC;
        end else if (wel_q && f_addr && is_erase_blk) begin
          // Erase needs the write latch; busy rising drops it
          state_d = ST_RUN;
          wel_d = 1'b0;
          start_d = 1'b1;
          if (op_q == `FES_OP_ERASE_4K) begin
            kind_d = `FES_KIND_4K;
            timer_d = SMALL_ERASE_CYC;
            start_addr_d = addr_q & `FES_MASK_4K;
          end else if (op_q == `FES_OP_ERASE_32K) begin
            kind_d = `FES_KIND_32K;
            timer_d = MID_ERASE_CYC;
            start_addr_d = addr_q & `FES_MASK_32K;
          end else begin
            kind_d = `FES_KIND_64K;
            timer_d = LARGE_ERASE_CYC;
            start_addr_d = addr_q & `FES_MASK_64K;
          end
        end else if (wel_q && f_op && is_chip) begin
          state_d = ST_RUN;
          wel_d = 1'b0;
          start_d = 1'b1;
          kind_d = `FES_KIND_CHIP;
          timer_d = WHOLE_ERASE_CYC;
        end else if (wel_q && f_data && is_prog) begin
          state_d = ST_RUN;
          wel_d = 1'b0;
          start_d = 1'b1;
          kind_d = `FES_KIND_PROG;
          timer_d = PROGRAM_CYC;
          start_addr_d = addr_q;
        end
      end
      ST_RUN: begin
        // Only status reads and suspend are heard while busy
        if (f_op && op_q == `FES_OP_SUSPEND && !sus_q && kind_q != `FES_KIND_CHIP) begin
          state_d = ST_SUSPENDING;
          sus_d = 1'b1;
          wait_d = SUS_CYC;
        end else if (timer_q <= 32'h1) begin
          state_d = ST_IDLE;
          timer_d = 32'h0;
        end else begin
          timer_d = timer_q - 32'h1;
        end
      end
      ST_SUSPENDING: begin
        // Remaining time is frozen so resume picks up where it left off
        if (wait_q <= 32'h1) begin
          state_d = ST_SUSP;
        end else begin
          wait_d = wait_q - 32'h1;
        end
      end
      ST_SUSP: begin
        // Erase, program and status-write opcodes fall through unheard
        if (f_op && op_q == `FES_OP_WRITE_ENABLE_CMD) begin
          wel_d = 1'b1;
        end else if (f_op && op_q == `FES_OP_RESUME && sus_q) begin
          state_d = ST_RUN;
          sus_d = 1'b0;
          wel_d = 1'b0;
        end
      end
      ST_PD_ENTER: begin
        if (wait_q <= 32'h1) begin
          state_d = ST_PD;
        end else begin
          wait_d = wait_q - 32'h1;
        end
      end
      ST_PD: begin
        if (f_op && op_q == `FES_OP_RELEASE) begin
          state_d = ST_RELEASE;
          wait_d = REL_CYC;
        end
      end
      ST_RELEASE: begin
        if (wait_q <= 32'h1) begin
          state_d = ST_IDLE;
        end else begin
          wait_d = wait_q - 32'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Reset stands for power loss: standby, no suspend, nothing pending
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h0;
      wait_q <= 32'h0;
      kind_q <= `FES_KIND_4K;
      wel_q <= 1'b0;
      sus_q <= 1'b0;
      op_start_o <= 1'b0;
      op_kind_o <= `FES_KIND_4K;
      op_addr_o <= 24'h000000;
      op_done_o <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      wait_q <= wait_d;
      kind_q <= kind_d;
      wel_q <= wel_d;
      sus_q <= sus_d;
      op_start_o <= start_d;
      if (start_d) begin
        op_kind_o <= kind_d;
        op_addr_o <= start_addr_d;
      end
      op_done_o <= (state_q == ST_RUN) && (state_d == ST_IDLE);
    end
  end

  // Busy holds through the suspend latency and returns one cycle after resume
  assign busy_o = (state_q == ST_RUN) | (state_q == ST_SUSPENDING);
  assign write_latch_flag_o = wel_q;
  assign suspend_flag_o = sus_q;
  assign powerdown_o = (state_q == ST_PD);

  // ****************************************
  // Status readout
  // ****************************************
  reg [7:0] out_q;
  reg read_q;
  wire can_read = (state_q != ST_PD) & (state_q != ST_RELEASE) & (state_q != ST_PD_ENTER);
  wire [7:0] sr1 = {`FES_SR1_PAD, wel_q, busy_o};
  wire [7:0] sr2 = {sus_q, `FES_SR2_PAD};

  always @(posedge clk_i) begin
    if (srst_i || !active) begin
      out_q <= 8'h00;
      read_q <= 1'b0;
    end else if (byte_done) begin
      // Status repeats every byte while select stays low
      if (nbytes_q == 3'h0) begin
        read_q <= can_read & ((byte_in == `FES_OP_RDSR1) | (byte_in == `FES_OP_RDSR2));
        out_q <= (byte_in == `FES_OP_RDSR2) ? sr2 : sr1;
      end else begin
        out_q <= (op_q == `FES_OP_RDSR2) ? sr2 : sr1;
      end
    end else if (sck_fall && bitcnt_q != `FES_BIT_FIRST) begin
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign miso_o = out_q[7];
  assign miso_oe_o = read_q;

endmodule // fes_core

`default_nettype wire

// ### verification/fes_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module fes_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Outputs watched
  input wire logic miso_oe_o,
  input wire logic op_start_o,
  input wire logic [2:0] op_kind_o,
  input wire logic [23:0] op_addr_o,
  input wire logic op_done_o,
  input wire logic busy_o,
  input wire logic write_latch_flag_o,
  input wire logic suspend_flag_o,
  input wire logic powerdown_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_start_busy; op_start_o |-> busy_o ##1 busy_o; endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not held");
  property p_start_wel; op_start_o |-> $past(write_latch_flag_o) && !write_latch_flag_o;
  endproperty
  a_start_wel: assert property (p_start_wel) else $error("latch wrong at start");
  property p_align;
    op_start_o |-> (op_addr_o & (op_kind_o == 3'h0 ? 24'h000fff : op_kind_o == 3'h1 ?
      24'h007fff : op_kind_o == 3'h2 ? 24'h00ffff : op_kind_o == 3'h3 ? 24'hffffff :
      24'h000000)) == 24'h000000;
  endproperty
  a_align: assert property (p_align) else $error("address not aligned");
  property p_done; $fell(busy_o) && !suspend_flag_o |-> op_done_o; endproperty
  a_done: assert property (p_done) else $error("busy fell without done");
  property p_sus;
    $rose(suspend_flag_o) |-> $past(busy_o) && op_kind_o != 3'h3 ##[1:502] !busy_o;
  endproperty
  a_sus: assert property (p_sus) else $error("bad suspend");
  property p_res; $fell(suspend_flag_o) |-> ##[0:50] busy_o; endproperty
  a_res: assert property (p_res) else $error("resume slow");
  property p_pd; powerdown_o |-> !miso_oe_o && !busy_o && !op_start_o; endproperty
  a_pd: assert property (p_pd) else $error("active in power-down");
  property p_boot; $fell(srst_i) |-> !powerdown_o && !suspend_flag_o && !busy_o; endproperty
  a_boot: assert property (p_boot) else $error("not standby after reset");
endmodule // fes_monitor
bind fes_core fes_monitor u_mon (.clk_i(clk_i), .srst_i(srst_i), .miso_oe_o(miso_oe_o),
  .op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
  .op_done_o(op_done_o), .busy_o(busy_o), .write_latch_flag_o(write_latch_flag_o),
  .suspend_flag_o(suspend_flag_o), .powerdown_o(powerdown_o));
`default_nettype wire

// ### verification/fes_host.sv
`timescale 1ns/10ps
`default_nettype none
module fes_host (
  // Link pins
  input wire logic miso_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic mosi_o,
  // Last byte read back
  output logic [7:0] rd_o
);
  // No array reads are issued at all
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
    rd_o = 8'h00;
  end
  // Idle data line keeps moving so a stale bit can never look valid
  initial begin
    #3;
    forever #16 if (cs_n_o) mosi_o = ~mosi_o;
  end
  // Mode 0, MSB first; a count off the byte boundary is a deliberate fault
  task automatic frame(input int n, input logic [39:0] d);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_o = d[39 - i];
      #32 sck_o = 1'b1;
      rd_o = {rd_o[6:0], miso_i};
      #32 sck_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    #64;
  endtask
endmodule // fes_host
`default_nettype wire

// ### verification/fes_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fes_core_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  wire cs_n, sck, mosi, miso, miso_oe, start, done, busy, write_latch_flag, suspend_flag, pd;
  wire [2:0] kind;
  wire [23:0] addr;
  wire [7:0] rd;
  int errors = 0, samples_checked = 0, cyc = 0, nst = 0, ndn = 0, tst = 0, tdn = 0;
  logic [2:0] k_s;
  logic [23:0] a_s;
  always #2 clk_i = ~clk_i;
  fes_core #(.SMALL_ERASE_CYC(32'h320), .MID_ERASE_CYC(32'h258), .LARGE_ERASE_CYC(32'h2bc),
    .WHOLE_ERASE_CYC(32'h384), .PROGRAM_CYC(32'h190)) DUT (.clk_i(clk_i), .srst_i(srst_i),
    .cs_n_i(cs_n), .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .op_start_o(start), .op_kind_o(kind), .op_addr_o(addr), .op_done_o(done),
    .busy_o(busy), .write_latch_flag_o(write_latch_flag), .suspend_flag_o(suspend_flag), .powerdown_o(pd));
  fes_host HOST (.miso_i(miso), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi), .rd_o(rd));
  task automatic close_out;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Pulses are caught here: starts land while a frame is still closing, dones during waits
  always @(posedge clk_i) begin
    cyc++;
    if (start) begin
      nst++;
      tst = cyc;
      k_s = kind;
      a_s = addr;
    end
    if (done) begin
      ndn++;
      tdn = cyc;
    end
    if (cyc == 40000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tx(input int n, input logic [39:0] d);
    @(posedge clk_i);
    #1 HOST.frame(n, d);
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk_i);
    #1;
  endtask
  task automatic t_reset;
    chk({write_latch_flag, busy, suspend_flag, pd, miso_oe}, 24'h0);
  endtask
  task automatic t_refuse;
    tx(32, {8'h20, 24'h001000, 8'h00});
    chk(nst, 24'h0);
    tx(8, {8'h06, 32'h0});
    tx(33, {8'h20, 24'h001000, 8'h00});
    chk({nst[1:0], write_latch_flag}, 24'h1);
  endtask
  task automatic t_erase;
    logic [7:0] ops [0:4] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    logic [23:0] msk [0:4] = '{24'hfff000, 24'hff8000, 24'hff0000, 24'h0, 24'h0};
    logic [2:0] kd [0:4] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3};
    int t [0:4] = '{32'h320, 32'h258, 32'h2bc, 32'h384, 32'h384};
    for (int i = 0; i < 5; i++) begin
      tx(8, {8'h06, 32'h0});
      chk(write_latch_flag, 1'b1);
      if (i < 3) tx(32, {ops[i], 24'h5a5a5a, 8'h00});
      else tx(8, {ops[i], 32'h5a5a5a00});
      chk(k_s, kd[i]);
      chk(a_s, 24'h5a5a5a & msk[i]);
      chk({busy, write_latch_flag}, 2'b10);
      if (i == 0) tx(16, {8'h05, 32'h0});
      if (i == 0) chk(rd, 8'h01);
      if (i > 2) tx(8, {8'h75, 32'h0});
      chk(suspend_flag, 1'b0);
      wait_idle();
      chk(tdn - tst >= t[i] - 2 && tdn - tst <= t[i] + 2, 1'b1);
    end
  endtask
  task automatic t_suspend;
    int s0;
    tx(8, {8'h06, 32'h0});
    tx(32, {8'h20, 24'h001fff, 8'h00});
    s0 = ndn;
    tx(8, {8'h75, 32'h0});
    chk(suspend_flag, 1'b1);
    repeat (510) @(posedge clk_i);
    chk(busy, 1'b0);
    tx(8, {8'h06, 32'h0});
    tx(32, {8'h52, 24'h0, 8'h00});
    chk(nst, 24'h6);
    tx(8, {8'h7a, 32'h0});
    chk({suspend_flag, busy, write_latch_flag}, 3'b010);
    // No second suspend is sent after a resume
    wait_idle();
    chk(ndn, s0 + 1);
    tx(8, {8'h06, 32'h0});
    tx(40, {8'h02, 24'h000123, 8'ha5});
    chk(k_s, 3'h4);
    chk(a_s, 24'h000123);
    tx(8, {8'h75, 32'h0});
    repeat (510) @(posedge clk_i);
    tx(8, {8'h06, 32'h0});
    tx(40, {8'h33, 24'h000200, 8'h5a});
    tx(8, {8'hc7, 32'h0});
    chk({nst[3:0], suspend_flag, busy}, {4'h7, 2'b10});
    tx(8, {8'h7a, 32'h0});
    wait_idle();
    chk(ndn, s0 + 2);
  endtask
  task automatic t_pd;
    tx(9, {8'hb9, 32'h0});
    repeat (800) @(posedge clk_i);
    chk(pd, 1'b0);
    tx(8, {8'hb9, 32'h0});
    repeat (760) @(posedge clk_i);
    chk(pd, 1'b1);
    tx(16, {8'h05, 32'h0});
    tx(8, {8'h06, 32'h0});
    chk(write_latch_flag, 1'b0);
    tx(8, {8'hab, 32'h0});
    chk(pd, 1'b0);
    repeat (760) @(posedge clk_i);
    tx(8, {8'h06, 32'h0});
    chk(write_latch_flag, 1'b1);
  endtask
  task automatic t_loss;
    int d0;
    tx(32, {8'hd8, 24'h030000, 8'h00});
    tx(8, {8'h75, 32'h0});
    d0 = ndn;
    @(posedge clk_i);
    #1 srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    chk({suspend_flag, busy, pd, write_latch_flag}, 24'h0);
    tx(8, {8'h7a, 32'h0});
    chk({suspend_flag, busy, ndn[3:0]}, d0[3:0]);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_refuse();
    t_erase();
    t_suspend();
    t_pd();
    t_loss();
    close_out();
  end
endmodule // fes_core_tb
`default_nettype wire
